// ===== pkg/aht_map.vh
`ifndef AHT_MAP_VH
`define AHT_MAP_VH
// per-channel register indices, channel n at base + n * stride
`define AHT_HYST_IDX 8'h15
`define AHT_HIGH_UPPER_IDX 8'h16
`define AHT_HIGH_LOWER_IDX 8'h17
`define AHT_LOW_UPPER_IDX 8'h18
`define AHT_LOW_LOWER_IDX 8'h19
`define AHT_CH_STRIDE 8'h05
`define AHT_LAST_IDX 8'h3C
// own control register: variant select
`define AHT_CFG_IDX 8'h40
// field positions
`define AHT_FIELD_MSB 7
`define AHT_FIELD_LSB 2
// reset values
`define AHT_HYST_RST 6'h00
`define AHT_HIGH_UPPER_RST 8'h01
`define AHT_HIGH_LOWER_RST 6'h01
`define AHT_LOW_UPPER_RST 8'h00
`define AHT_LOW_LOWER_RST 6'h00
`endif

// ===== rtl/aht_regs.v
// Contract
// - hysteresis register bits 7..2 hold a writable 6-bit band, shared by high and low
// - band value k gives plus or minus k codes; zero means none
// - bits 1..0 of hysteresis and high lower registers read zero, ignore writes
// - high upper register holds threshold bits 13..6, read and write
// - high lower register bits 7..2 hold threshold bits 5..0, read and write
// - threshold is upper byte joined above lower six bits, left aligned in 16
// - each channel owns five consecutive byte registers, 14-bit high and low limits
// - four-channel variant ignores writes to channels 4..7 and reads all ones
//
// Implementation choice: the Avalon-MM register port.
`include "aht_map.vh"

module aht_regs #(
	parameter CHANNELS = 8
) (
	// clock and reset
	input wire clock_i,
	input wire nrst_i,
	// avalon-mm slave, word addressed by register index
	input wire [7:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	output wire [31:0] readdata_o,
	output wire waitrequest_o,
	// settings toward the comparators
	output wire [CHANNELS*6-1:0] alarm_band_width_o,
	output wire [CHANNELS*16-1:0] high_limit_o,
	output wire [CHANNELS*16-1:0] low_limit_o,
	output wire four_channel_o
);

////////////////////////////////////////////////////////////////////////////////
// address decode

	// returns channel index, or 15 if index lies outside the threshold block
	function [3:0] chan_of;
		input [7:0] idx;
		reg [7:0] rel;
		reg [7:0] quo;
		begin
			rel = idx - `AHT_HYST_IDX;
			// quotient never exceeds 7 inside the block, so four bits suffice
			quo = rel / `AHT_CH_STRIDE;
			if (idx < `AHT_HYST_IDX || idx > `AHT_LAST_IDX)
				chan_of = 4'hF;
			else
				chan_of = quo[3:0];
		end
	endfunction

	// slot 0..4 within a channel
	function [2:0] slot_of;
		input [7:0] idx;
		reg [7:0] rel;
		reg [7:0] rem;
		begin
			rel = idx - `AHT_HYST_IDX;
			rem = rel % `AHT_CH_STRIDE;
			slot_of = rem[2:0];
		end
	endfunction

	// read view of one channel slot; the fixed zero bits are packed here and in the limit outputs
	function [7:0] slot_view;
		input [2:0] slot;
		input [5:0] hyst;
		input [7:0] hup;
		input [5:0] hlo;
		input [7:0] lup;
		input [5:0] llo;
		begin
			case (slot)
				3'd0: slot_view = {hyst, 2'b00};
				3'd1: slot_view = hup;
				3'd2: slot_view = {hlo, 2'b00};
				3'd3: slot_view = lup;
				3'd4: slot_view = {llo, 2'b00};
				default: slot_view = 8'h00;
			endcase
		end
	endfunction

	wire [3:0] acc_ch = chan_of(address_i);
	wire [2:0] acc_slot = slot_of(address_i);
	wire in_block = (acc_ch != 4'hF);
	wire is_cfg = (address_i == `AHT_CFG_IDX);

////////////////////////////////////////////////////////////////////////////////
// bus answer sequencer

	// one-hot: idle waits for a request, answer lasts exactly one cycle
	localparam ST_IDLE = 2'b01;
	localparam ST_ANSWER = 2'b10;

	reg [1:0] state_reg;
	reg [1:0] state_next;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (read_i | write_i)
					state_next = ST_ANSWER;
			end
			ST_ANSWER: begin
				// back to idle so back-to-back requests each wait once
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (!nrst_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	wire ack_now = (state_reg == ST_ANSWER);

	reg four_ch_reg;
	reg [31:0] rdata_reg;

	// one wait state: request is accepted at the edge where ack_now is high
	assign waitrequest_o = (read_i | write_i) & ~ack_now;
	assign readdata_o = rdata_reg;
	assign four_channel_o = four_ch_reg;

	// writes land only at the accepting edge, never while stalled
	wire wr_fire = write_i & ack_now;
	// channels 4..7 absent on the small variant
	wire hidden = four_ch_reg & (acc_ch >= 4'd4) & in_block;

////////////////////////////////////////////////////////////////////////////////
// per-channel storage

	wire [7:0] rd_vec [0:CHANNELS-1];

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : ch
			reg [5:0] hyst_reg;
			reg [7:0] hup_reg;
			reg [5:0] hlo_reg;
			reg [7:0] lup_reg;
			reg [5:0] llo_reg;
			wire sel = wr_fire & in_block & ~hidden & (acc_ch == g);
			wire hyst_we = sel & (acc_slot == 3'd0);
			wire hup_we = sel & (acc_slot == 3'd1);
			wire hlo_we = sel & (acc_slot == 3'd2);
			wire lup_we = sel & (acc_slot == 3'd3);
			wire llo_we = sel & (acc_slot == 3'd4);

			// written bits 1..0 are dropped here, not stored
			always @(posedge clock_i) begin
				if (!nrst_i)
					hyst_reg <= `AHT_HYST_RST;
				else if (hyst_we)
					hyst_reg <= writedata_i[7:2];
			end

			always @(posedge clock_i) begin
				if (!nrst_i)
					hup_reg <= `AHT_HIGH_UPPER_RST;
				else if (hup_we)
					hup_reg <= writedata_i[7:0];
			end

			always @(posedge clock_i) begin
				if (!nrst_i)
					hlo_reg <= `AHT_HIGH_LOWER_RST;
				else if (hlo_we)
					hlo_reg <= writedata_i[7:2];
			end

			always @(posedge clock_i) begin
				if (!nrst_i)
					lup_reg <= `AHT_LOW_UPPER_RST;
				else if (lup_we)
					lup_reg <= writedata_i[7:0];
			end

			always @(posedge clock_i) begin
				if (!nrst_i)
					llo_reg <= `AHT_LOW_LOWER_RST;
				else if (llo_we)
					llo_reg <= writedata_i[7:2];
			end

			// band is raw code count, no scaling applied downstream
			assign alarm_band_width_o[g*6 +: 6] = hyst_reg;
			assign high_limit_o[g*16 +: 16] = {hup_reg, hlo_reg, 2'b00};
			assign low_limit_o[g*16 +: 16] = {lup_reg, llo_reg, 2'b00};
			assign rd_vec[g] = slot_view(acc_slot, hyst_reg, hup_reg, hlo_reg, lup_reg, llo_reg);
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////
// read data and variant control

	// read data is captured in the stall cycle, so it stands at the accepting edge
	always @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (read_i & ~ack_now) begin
			if (hidden)
				rdata_reg <= 32'h0000_00FF;
			else if (in_block && acc_ch < CHANNELS)
				rdata_reg <= {24'h00_0000, rd_vec[acc_ch[2:0]]};
			else if (is_cfg)
				rdata_reg <= {31'h0000_0000, four_ch_reg};
			else
				rdata_reg <= 32'h0000_0000;
		end
	end

	// variant select is a local setting; reset favours the eight-channel map
	always @(posedge clock_i) begin
		if (!nrst_i)
			four_ch_reg <= 1'b0;
		else if (wr_fire & is_cfg)
			four_ch_reg <= writedata_i[0];
	end

endmodule

// ===== test/aht_regs_assertions.sv
module aht_chk #(parameter CHANNELS = 8) (
	input logic clock_i, nrst_i, read_i, write_i, waitrequest_o, four_channel_o,
	input logic [7:0] address_i,
	input logic [31:0] writedata_i, readdata_o,
	input logic [CHANNELS*6-1:0] alarm_band_width_o,
	input logic [CHANNELS*16-1:0] high_limit_o, low_limit_o);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	wire rd = read_i && !waitrequest_o;
	wire wr = write_i && !waitrequest_o;
	// slot of the index within its channel; slots 0 and 2 carry zero low bits
	wire [7:0] rel = address_i - 8'h15;
	wire [7:0] slot = rel % 8'h05;
	wire zero_pair = address_i >= 8'h15 && address_i <= 8'h3C && (slot == 8'h00 || slot == 8'h02)
		&& !(four_channel_o && address_i >= 8'h29);
	// write data of the accepting edge, for checks one cycle on
	logic [7:0] wd;
	always_ff @(posedge clock_i) wd <= writedata_i[7:0];
	a_band_write: assert property (wr && address_i == 8'h15 |=> alarm_band_width_o[5:0] == wd[7:2])
		else $error("band write lost");
	a_band_hold: assert property (!wr |=> $stable(alarm_band_width_o))
		else $error("band moved");
	a_low_bits_zero: assert property (rd && zero_pair |-> readdata_o[1:0] == 2'h0)
		else $error("low bits set");
	a_upper_write: assert property (wr && address_i == 8'h16 |=> high_limit_o[15:8] == wd)
		else $error("upper write lost");
	a_lower_write: assert property (wr && address_i == 8'h17 |=> high_limit_o[7:2] == wd[7:2])
		else $error("lower write lost");
	a_upper_join: assert property (rd && address_i == 8'h16 |-> readdata_o[7:0] == high_limit_o[15:8])
		else $error("join wrong");
	a_chan_stride: assert property (wr && address_i == 8'h1B |=> high_limit_o[31:24] == wd)
		else $error("stride wrong");
	a_narrow_ones: assert property (rd && four_channel_o && address_i inside {[8'h29:8'h3C]}
		|-> readdata_o[7:0] == 8'hFF)
		else $error("hidden channel read");
	cover property (rd && four_channel_o);
	cover property (wr && address_i == 8'h1B);
	cover property (rd && address_i == 8'h17);
endmodule
bind aht_regs aht_chk #(.CHANNELS(CHANNELS)) chk_u (.*);

// ===== test/tb_aht_regs.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("mismatch %0t got %h want %h", $time, a, b); end end
module tb_aht_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i = 0, nrst_i = 0, read_i = 0, write_i = 0;
	logic [7:0] address_i = 8'h00, q;
	logic [31:0] writedata_i = 32'h0;
	wire [31:0] readdata_o;
	wire waitrequest_o, four_channel_o;
	wire [47:0] alarm_band_width_o;
	wire [127:0] high_limit_o, low_limit_o;
	int err_total = 0, tests_run = 0, cyc = 0;
	aht_regs dut_u (.*);
	initial forever #5 clock_i = ~clock_i;
	always @(posedge clock_i) if (++cyc == 3000) begin
		err_total++;
		results();
	end
	// one bus transfer; an idle edge after release keeps drivers single per step
	task automatic xf(input logic w, input logic [7:0] a, d = 8'h00);
		address_i <= a; writedata_i <= {24'h0, d}; read_i <= !w; write_i <= w;
		do @(posedge clock_i); while (waitrequest_o !== 1'b0);
		q = readdata_o[7:0]; read_i <= 0; write_i <= 0;
		@(posedge clock_i);
	endtask
	task t_reset;
		xf(0, 8'h16); `CHK(q, 8'h01)
		xf(0, 8'h17); `CHK(q, 8'h04)
		xf(0, 8'h15); `CHK(q, 8'h00)
	endtask
	task t_hyst;
		xf(1, 8'h15, 8'hFF); xf(0, 8'h15); `CHK(q, 8'hFC)
		`CHK(alarm_band_width_o[5:0], 6'h3F)
		xf(1, 8'h15, 8'h04); `CHK(alarm_band_width_o[5:0], 6'h01)
	endtask
	task t_high;
		xf(1, 8'h16, 8'hAA); xf(1, 8'h17, 8'hFF); xf(0, 8'h17); `CHK(q, 8'hFC)
		`CHK(high_limit_o[15:0], 16'hAAFC)
		xf(1, 8'h1B, 8'h5A); `CHK(high_limit_o[31:16], 16'h5A04)
		xf(0, 8'h50); `CHK(q, 8'h00)
	endtask
	task t_low;
		xf(1, 8'h18, 8'h3C); xf(1, 8'h19, 8'h07); `CHK(low_limit_o[15:0], 16'h3C04)
		xf(0, 8'h19); `CHK(q, 8'h04)
		`CHK(readdata_o[31:8], 24'h00_0000)
		xf(1, 8'h2A, 8'h33); `CHK(high_limit_o[79:72], 8'h33)
		xf(0, 8'h2A); `CHK(q, 8'h33)
	endtask
	task t_four;
		xf(1, 8'h40, 8'h01); `CHK(four_channel_o, 1'b1)
		xf(0, 8'h40); `CHK(q, 8'h01)
		xf(1, 8'h2A, 8'hC3); xf(0, 8'h2A); `CHK(q, 8'hFF)
		`CHK(high_limit_o[79:72], 8'h33)
	endtask
	task t_rst2;
		nrst_i <= 0;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1;
		`CHK(four_channel_o, 1'b0)
		`CHK(high_limit_o[79:64], 16'h0104)
		`CHK(alarm_band_width_o[5:0], 6'h00)
		t_reset();
	endtask
	task results;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		nrst_i <= 1;
		t_reset();
		t_hyst();
		t_high();
		t_low();
		t_four();
		t_rst2();
		results();
	end
endmodule
